// >>> include/fp_gpr_if.sv
interface fp_gpr_if;
    logic [2:0] wr_en;
    logic [2:0][4:0] wr_idx;
    logic [2:0][31:0] wr_data;
    logic rd_en;
    logic [4:0] rd_idx;
    logic [31:0] rd_data;
    modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx,
        input rd_data);
    modport file (input wr_en, wr_idx, wr_data, rd_en, rd_idx,
        output rd_data);
endinterface

// >>> include/fp_state_pkg.sv
package fp_state_pkg;
    localparam int IDX_W = 5;
    localparam int DATA_W = 32;
    localparam int NUM_GPR = 32;
    localparam int NUM_RES = 2;
    localparam int WR_PORTS = 3;
    localparam int ACC_LAT = 1;
    localparam logic [4:0] ID_SLOT = 5'h00;
    localparam logic [4:0] CSR_SLOT = 5'h1F;
    localparam int RM_LSB = 0;
    localparam int FLAG_LSB = 2;
    localparam int EN_LSB = 7;
    localparam int CAUSE_LSB = 12;
    localparam int CAUSE_E_BIT = 5;
    localparam int COND_BIT = 23;
    localparam int FS_BIT = 24;
    localparam int ID_IMP_LSB = 8;
    localparam int ID_MAJOR_LSB = 4;
    localparam int ID_MINOR_LSB = 0;
    localparam logic [31:0] CSR_WMASK = 32'h0183FFFF;
    localparam logic [31:0] CSR_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        RND_NEAREST, RND_ZERO, RND_PLUS, RND_MINUS
    } rounding_type;
    typedef enum logic {CTL_IDLE, CTL_DRAIN} ctl_state_type;
endpackage

// >>> src/fp_coproc_state.sv
module fp_coproc_state #(
    parameter logic [7:0] ID_IMP = 8'h5A, // Arbitrary value
    parameter logic [3:0] ID_MAJOR = 4'h1, // Arbitrary value
    parameter logic [3:0] ID_MINOR = 4'h0 // Arbitrary value
) (
    input wire logic clk, // Core clock, 20 MHz
    input wire logic rst_n, // Synchronous reset
    input wire logic ce, // Freezes all state when low
    input wire logic reg_pairing_mode_bit, // Operand view select
    input wire logic acc_valid, // Register access request
    input wire logic acc_write, // 1 write, 0 read
    input wire logic acc_operand, // 1 operand view, 0 general view
    input wire logic [4:0] acc_idx, // Register number
    input wire logic [31:0] acc_wdata, // Write data
    output logic [31:0] acc_rdata, // Read data
    output logic acc_done, // Access finished pulse
    output logic acc_trap, // Unimplemented trap pulse
    input wire logic [1:0] res_valid, // Result strobes, 0 add, 1 mult
    input wire logic [1:0][4:0] res_dest, // Result target register
    input wire logic [1:0][31:0] res_data, // Result value
    input wire logic [1:0][5:0] res_cause, // Raw cause E,V,Z,O,U,I
    input wire logic [1:0] res_denorm, // Result is denormal
    input wire logic [1:0] res_cmp, // Operation is a compare
    input wire logic [1:0] res_cond, // Compare outcome
    input wire logic ops_pending, // Operations still in flight
    input wire logic ctl_valid, // Control move request
    input wire logic ctl_write, // 1 move-to, 0 move-from
    input wire logic [4:0] ctl_slot, // Control slot number
    input wire logic [31:0] ctl_wdata, // Move-to data
    output logic [31:0] ctl_rdata, // Move-from data
    output logic ctl_done, // Control move finished pulse
    output logic ctl_retry, // Read aborted, reissue pulse
    output logic ctl_busy, // Request not accepted
    output logic [1:0] rounding_select, // Rounding mode
    output logic flush_denorm_enable, // Flush denormals to zero
    output logic condition_out, // Compare condition bit
    output logic fp_exception // Exception pulse
);
    fp_gpr_if gpr ();
    fp_state_pkg::ctl_state_type state_q;
    logic [31:0] csr_q;
    logic wr_q;
    logic [4:0] slot_q;
    logic [31:0] wdata_q;
    logic [31:0] ctl_rdata_q;
    logic ctl_done_q;
    logic ctl_retry_q;
    logic exc_q;
    logic acc_done_q;
    logic acc_trap_q;
    logic [1:0][5:0] eff;
    logic [1:0] hit;
    logic [5:0] cause_or;
    logic [4:0] flag_or;
    logic cmp_upd;
    logic cmp_val;
    logic exc_now;
    logic fire;
    logic trap;
    logic [4:0] en_f;
    logic fs;
    logic csr_wr;
    logic [5:0] w_cause;

    // Exception when cause E is set or any other cause bit is enabled
    function automatic logic exc_hit(input logic [5:0] c,
            input logic [4:0] en);
        return c[fp_state_pkg::CAUSE_E_BIT] | (|(c[4:0] & en));
    endfunction

    fp_gpr_file u_gpr (
        .clk(clk),
        .ce(ce),
        .port(gpr.file)
    );

    assign en_f = csr_q[fp_state_pkg::EN_LSB +: 5];
    assign fs = csr_q[fp_state_pkg::FS_BIT];

    // Field outputs straight from the register
    assign rounding_select = csr_q[fp_state_pkg::RM_LSB +: 2];
    assign flush_denorm_enable = fs;
    assign condition_out = csr_q[fp_state_pkg::COND_BIT];

    // Odd operand number only illegal in the unpaired view
    assign trap = acc_operand && !reg_pairing_mode_bit
        && acc_idx[0];

    // Port 0 of the file serves moves, loads and stores
    // Even operand numbers map one to one onto general numbers
    assign gpr.wr_en[0] = acc_valid && acc_write && !trap;
    assign gpr.wr_idx[0] = acc_idx;
    assign gpr.wr_data[0] = acc_wdata;
    assign gpr.rd_en = acc_valid && !acc_write && !trap;
    assign gpr.rd_idx = acc_idx;

    // Access answers exactly one cycle later
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_done_q <= 1'b0;
            acc_trap_q <= 1'b0;
        end else if (ce) begin
            acc_done_q <= acc_valid;
            acc_trap_q <= acc_valid && trap;
        end
    end

    assign acc_done = acc_done_q;
    assign acc_trap = acc_trap_q;
    assign acc_rdata = gpr.rd_data;

    // Effective cause per result; denormal adds E unless flushed
    always_comb begin
        logic [5:0] c;
        c = '0;
        cause_or = '0;
        flag_or = '0;
        cmp_upd = 1'b0;
        cmp_val = 1'b0;
        for (int i = 0; i < fp_state_pkg::NUM_RES; i++) begin
            c = res_cause[i];
            if (res_denorm[i] && !fs) begin
                c[fp_state_pkg::CAUSE_E_BIT] = 1'b1;
            end
            eff[i] = res_valid[i] ? c : 6'h00;
            hit[i] = res_valid[i] && exc_hit(c, en_f);
            cause_or = cause_or | eff[i];
            if (!hit[i]) begin
                flag_or = flag_or | eff[i][4:0];
            end
            if (res_valid[i] && res_cmp[i] && !hit[i]) begin
                cmp_upd = 1'b1;
                cmp_val = res_cond[i];
            end
        end
    end

    assign exc_now = |hit;

    // Two result ports so multiply and add overlap
    // A trapped result is not stored; compares store nothing
    for (genvar g = 0; g < fp_state_pkg::NUM_RES; g++) begin : g_res
        assign gpr.wr_en[g + 1] = res_valid[g] && !hit[g] && !res_cmp[g];
        assign gpr.wr_idx[g + 1] = res_dest[g];
        assign gpr.wr_data[g + 1] = (res_denorm[g] && fs)
            ? {res_data[g][31], 31'h00000000} : res_data[g];
    end

    // Control move goes only when the pipe is empty and quiet
    assign fire = (state_q == fp_state_pkg::CTL_DRAIN) && !ops_pending
        && !(|res_valid);
    assign csr_wr = fire && wr_q
        && (slot_q == fp_state_pkg::CSR_SLOT);
    assign w_cause = wdata_q[fp_state_pkg::CAUSE_LSB +: 6];
    assign ctl_busy = (state_q != fp_state_pkg::CTL_IDLE);

    // Control move sequencer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= fp_state_pkg::CTL_IDLE;
        end else if (ce) begin
            case (state_q)
                fp_state_pkg::CTL_IDLE: begin
                    if (ctl_valid) begin
                        state_q <= fp_state_pkg::CTL_DRAIN;
                    end
                end
                fp_state_pkg::CTL_DRAIN: begin
                    if ((!wr_q && exc_now) || fire) begin
                        state_q <= fp_state_pkg::CTL_IDLE;
                    end
                end
                default: begin
                    state_q <= fp_state_pkg::CTL_IDLE;
                end
            endcase
        end
    end

    // Request capture; only the control port reaches the slots
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            slot_q <= 5'h00;
            wdata_q <= 32'h00000000;
        end else if (ce && !ctl_busy && ctl_valid) begin
            wr_q <= ctl_write;
            slot_q <= ctl_slot;
            wdata_q <= ctl_wdata;
        end
    end

    // Control read data and completion pulses
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctl_rdata_q <= 32'h00000000;
            ctl_done_q <= 1'b0;
            ctl_retry_q <= 1'b0;
        end else if (ce) begin
            ctl_done_q <= fire;
            ctl_retry_q <= (state_q == fp_state_pkg::CTL_DRAIN)
                && !wr_q && exc_now;
            if (fire && !wr_q) begin
                case (slot_q)
                    fp_state_pkg::ID_SLOT: begin
                        ctl_rdata_q <= {16'h0000, ID_IMP,
                            ID_MAJOR, ID_MINOR};
                    end
                    fp_state_pkg::CSR_SLOT: begin
                        ctl_rdata_q <= csr_q;
                    end
                    default: begin
                        ctl_rdata_q <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    assign ctl_rdata = ctl_rdata_q;
    assign ctl_done = ctl_done_q;
    assign ctl_retry = ctl_retry_q;

    // Control/status; a write only happens with no result in flight,
    // so hardware flag sets and software clears never collide
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            csr_q <= fp_state_pkg::CSR_RESET;
        end else if (ce) begin
            if (csr_wr) begin
                csr_q <= wdata_q & fp_state_pkg::CSR_WMASK;
            end else if (|res_valid) begin
                csr_q[fp_state_pkg::CAUSE_LSB +: 6] <= cause_or;
                csr_q[fp_state_pkg::FLAG_LSB +: 5] <=
                    csr_q[fp_state_pkg::FLAG_LSB +: 5] | flag_or;
                if (cmp_upd) begin
                    csr_q[fp_state_pkg::COND_BIT] <= cmp_val;
                end
            end
        end
    end

    // Exception from a trapped result or from writing enabled cause bits
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            exc_q <= 1'b0;
        end else if (ce) begin
            exc_q <= exc_now || (csr_wr && exc_hit(w_cause,
                wdata_q[fp_state_pkg::EN_LSB +: 5]));
        end
    end

    assign fp_exception = exc_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_drain_exc;
        ce && state_q == fp_state_pkg::CTL_DRAIN && !wr_q && exc_now;
    endsequence
    sequence s_retry;
        ctl_retry && !ctl_done && !ctl_busy;
    endsequence

    odd_trap_a: assert property (ce && acc_valid && trap
        |=> acc_trap && acc_done)
        else $error("odd operand did not trap");
    paired_ok_a: assert property (ce && acc_valid
        && reg_pairing_mode_bit |=> !acc_trap)
        else $error("trap in paired view");
    acc_one_cycle_a: assert property (ce && acc_valid
        |=> acc_done)
        else $error("access not done in one cycle");
    read_drained_a: assert property (fire && !wr_q
        |-> !ops_pending && res_valid == 2'b00)
        else $error("control read before drain");
    write_held_a: assert property (csr_wr |-> !ops_pending)
        else $error("control write before drain");
    retry_read_a: assert property (s_drain_exc |=> s_retry)
        else $error("read not aborted on exception");
    cond_kept_a: assert property (ce && !cmp_upd && !csr_wr
        |=> $stable(csr_q[fp_state_pkg::COND_BIT]))
        else $error("condition bit changed");
    cmp_cond_a: assert property (ce && res_valid == 2'b01
        && res_cmp[0] && !hit[0] |=> condition_out == $past(res_cond[0]))
        else $error("compare outcome not stored");
    flush_zero_a: assert property (res_valid[0] && res_denorm[0]
        && fs |-> gpr.wr_data[1][30:0] == 31'h00000000)
        else $error("denormal not flushed");
    reserved_a: assert property (ce && fire && !wr_q
        && slot_q != fp_state_pkg::ID_SLOT
        && slot_q != fp_state_pkg::CSR_SLOT |=> ctl_rdata == 32'h00000000)
        else $error("reserved slot read nonzero");
    id_read_a: assert property (ce && fire && !wr_q
        && slot_q == fp_state_pkg::ID_SLOT
        |=> ctl_rdata[7:0] == {ID_MAJOR, ID_MINOR})
        else $error("identification read wrong");
endmodule // fp_coproc_state

// >>> src/fp_gpr_file.sv
module fp_gpr_file (
    input wire logic clk, // Core clock
    input wire logic ce, // Clock enable
    fp_gpr_if.file port // Read and write ports
);
    logic [31:0] mem_q [fp_state_pkg::NUM_GPR];
    logic [31:0] rd_q;

    // No reset on the array: contents undefined until written
    always_ff @(posedge clk) begin
        if (ce) begin
            for (int p = 0; p < fp_state_pkg::WR_PORTS; p++) begin
                if (port.wr_en[p]) begin
                    mem_q[port.wr_idx[p]] <= port.wr_data[p];
                end
            end
        end
    end

    // Registered read, one cycle after the request
    always_ff @(posedge clk) begin
        if (ce && port.rd_en) begin
            rd_q <= mem_q[port.rd_idx];
        end
    end

    assign port.rd_data = rd_q;
endmodule // fp_gpr_file

// >>> verification/fp_pipe_model.sv
module fp_pipe_model (
    input wire logic clk, // Core clock
    output logic ops_pending, // Operations in flight
    output logic [1:0] res_valid, // Result strobes
    output logic [1:0][4:0] res_dest, // Result target register
    output logic [1:0][31:0] res_data, // Result value
    output logic [1:0][5:0] res_cause, // Raw cause bits
    output logic [1:0] res_denorm, // Result is denormal
    output logic [1:0] res_cmp, // Operation is a compare
    output logic [1:0] res_cond // Compare outcome
);
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {int t; int p; logic [4:0] d; logic [31:0] v;
        logic [5:0] c; logic dn, cp, cd;} op_type;
    op_type q[$];

    // Quiet buses at time zero
    initial begin
        ops_pending = 1'h0;
        res_valid = 2'h0;
        res_dest = '0;
        res_data = '0;
        {res_cause, res_denorm, res_cmp, res_cond} = '0;
    end

    // Pending rises at once so a control move issued next is held off
    task automatic issue(input int lat, input int p, input logic [4:0] d,
        input logic [31:0] v, input logic [5:0] c, input logic dn, cp, cd);
        q.push_back('{lat, p, d, v, c, dn, cp, cd});
        ops_pending = 1'h1;
    endtask

    // Retire ops whose latency ran out; idle data flips to its inverse each cycle
    always @(negedge clk) begin
        res_valid = 2'h0;
        res_data = ~res_data;
        for (int i = q.size() - 1; i >= 0; i--) begin
            q[i].t = q[i].t - 1;
            if (q[i].t <= 0) begin
                res_valid[q[i].p] = 1'h1;
                res_dest[q[i].p] = q[i].d;
                res_data[q[i].p] = q[i].v;
                res_cause[q[i].p] = q[i].c;
                res_denorm[q[i].p] = q[i].dn;
                res_cmp[q[i].p] = q[i].cp;
                res_cond[q[i].p] = q[i].cd;
                q.delete(i);
            end
        end
        ops_pending = q.size() != 0;
    end
endmodule // fp_pipe_model

// >>> verification/tb_fp_coproc_state.sv
module tb_fp_coproc_state;
    timeunit 1ns;
    timeprecision 1ps;
    // Arbitrary identification value, not a real part code
    localparam logic [31:0] ID_EXP = 32'h00003C27;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic ce = 1'h1;
    logic reg_pairing_mode_bit = 1'h0;
    logic acc_valid = 1'h0, acc_write = 1'h0, acc_operand = 1'h0;
    logic ctl_valid = 1'h0, ctl_write = 1'h0;
    logic [4:0] acc_idx = 5'h00, ctl_slot = 5'h00;
    logic [31:0] acc_wdata = 32'h00000000, ctl_wdata = 32'h00000000;
    logic [31:0] acc_rdata, ctl_rdata;
    logic acc_done, acc_trap, ctl_done, ctl_retry, ctl_busy, ops_pending;
    logic flush_denorm_enable, condition_out, fp_exception;
    logic [1:0] rounding_select, res_valid, res_denorm, res_cmp, res_cond;
    logic [1:0][4:0] res_dest;
    logic [1:0][31:0] res_data;
    logic [1:0][5:0] res_cause;
    logic [31:0] gm [32];
    logic [31:0] cm = 32'h00000000;
    logic [31:0] seed = 32'h0000D7A3;
    int mismatches = 0, checks = 0, exp_exc = 0, got_exc = 0, cycles = 0;

    always #25 clk = ~clk;

    fp_coproc_state #(.ID_IMP(8'h3C), .ID_MAJOR(4'h2), .ID_MINOR(4'h7))
        i_fp_coproc_state (.clk, .rst_n, .ce, .reg_pairing_mode_bit,
        .acc_valid, .acc_write, .acc_operand, .acc_idx, .acc_wdata,
        .acc_rdata, .acc_done, .acc_trap, .res_valid, .res_dest, .res_data,
        .res_cause, .res_denorm, .res_cmp, .res_cond, .ops_pending,
        .ctl_valid, .ctl_write, .ctl_slot, .ctl_wdata, .ctl_rdata,
        .ctl_done, .ctl_retry, .ctl_busy, .rounding_select,
        .flush_denorm_enable, .condition_out, .fp_exception);
    fp_pipe_model i_fp_pipe_model (.clk, .ops_pending, .res_valid,
        .res_dest, .res_data, .res_cause, .res_denorm, .res_cmp, .res_cond);

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_data(input string what, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input string what, input logic got, exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s %b not %b", $time, what, got, exp);
        end
    endtask

    // Exception pulses and hang guard
    always @(posedge clk) begin
        cycles++;
        if (fp_exception === 1'h1) got_exc++;
        if (cycles == 6000) begin
            mismatches++;
            print_verdict();
        end
    end

    // One register access; answer is checked in the cycle after the take
    task automatic acc(input logic wr, op, input logic [4:0] idx,
        input logic [31:0] wd);
        logic trap;
        trap = op && !reg_pairing_mode_bit && idx[0];
        @(negedge clk);
        {acc_valid, acc_write, acc_operand, acc_idx, acc_wdata} =
            {1'h1, wr, op, idx, wd};
        @(negedge clk);
        acc_valid = 1'h0;
        chk_bit("acc done", acc_done, 1'h1);
        chk_bit("acc trap", acc_trap, trap);
        if (!wr && !trap) chk_data("gpr", acc_rdata, gm[idx]);
        if (wr && !trap) gm[idx] = wd;
    endtask

    // Control move; waits boundedly for done or retry
    task automatic ctl(input logic wr, input logic [4:0] slot,
        input logic [31:0] wd, input logic retry);
        int n;
        logic [31:0] exp;
        exp = slot == 5'h1F ? cm : slot == 5'h00 ? ID_EXP : 32'h00000000;
        @(negedge clk);
        {ctl_valid, ctl_write, ctl_slot, ctl_wdata} = {1'h1, wr, slot, wd};
        @(negedge clk);
        ctl_valid = 1'h0;
        chk_bit("busy", ctl_busy, 1'h1);
        n = 0;
        while (ctl_done !== 1'h1 && ctl_retry !== 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk_bit("retry", ctl_retry, retry);
        chk_bit("done", ctl_done, !retry);
        chk_bit("idle", ctl_busy, 1'h0);
        chk_bit("drained", ops_pending, 1'h0);
        if (!wr && !retry) begin
            chk_data("ctl", ctl_rdata, exp);
        end
        // Writing a cause together with its enable raises an exception
        if (wr && slot == 5'h1F) begin
            cm = (wd & fp_state_pkg::CSR_WMASK)
                | (cm & ~fp_state_pkg::CSR_WMASK);
            exp_exc += wd[17] | (|(wd[16:12] & wd[11:7]));
        end
    endtask

    // Output fields come straight from the control register, so let it settle first
    task automatic chk_out();
        repeat (2) @(negedge clk);
        chk_data("rm", 32'(rounding_select), 32'(cm[1:0]));
        chk_bit("flush", flush_denorm_enable, cm[24]);
        chk_bit("cond", condition_out, cm[23]);
    endtask

    // Issue one operation and update the reference state at once
    task automatic op(input int p, lat, input logic [4:0] d,
        input logic [31:0] v, input logic [5:0] c, input logic dn, cp, cd);
        logic [5:0] k;
        logic [31:0] w;
        logic e;
        k = c;
        w = (dn && cm[24]) ? {v[31], 31'h0} : v;
        if (dn && !cm[24]) k[5] = 1'h1;
        e = k[5] | (|(k[4:0] & cm[11:7]));
        cm[17:12] = k;
        if (!e) begin
            cm[6:2] = cm[6:2] | k[4:0];
            if (cp) cm[23] = cd;
            else gm[d] = w;
        end
        exp_exc += e;
        i_fp_pipe_model.issue(lat, p, d, v, c, dn, cp, cd);
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) rst_n = 1'h1;
        chk_out();
        ctl(1'h0, 5'h1F, 32'h00000000, 1'h0);
        $display("test reset done");
        for (int i = 0; i < 32; i++) begin
            acc(1'h1, 1'h0, i[4:0], rnd());
        end
        for (int i = 0; i < 32; i++) begin
            acc(1'h0, 1'h0, i[4:0], 32'h0);
        end
        for (int m = 0; m < 2; m++) begin
            reg_pairing_mode_bit = m[0];
            for (int i = 0; i < 32; i++) begin
                acc(1'h0, 1'h1, i[4:0], 32'h0);
                acc(1'h1, 1'h1, i[4:0], rnd());
            end
        end
        $display("test register views done");
        for (int s = 0; s < 32; s++) begin
            ctl(1'h1, s[4:0], rnd() & 32'hFFFC0FFF, 1'h0);
            ctl(1'h0, s[4:0], 32'h0, 1'h0);
        end
        for (int r = 0; r < 4; r++) begin
            ctl(1'h1, 5'h1F, {7'h0, r[1], 22'h0, r[1:0]}, 1'h0);
            chk_out();
        end
        $display("test control slots done");
        op(0, 6, 5'h03, rnd(), 6'h01, 1'h0, 1'h0, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h0);
        op(1, 4, 5'h00, 32'h0, 6'h00, 1'h0, 1'h1, 1'h1);
        op(0, 5, 5'h08, rnd(), 6'h00, 1'h0, 1'h0, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h0);
        chk_out();
        op(0, 3, 5'h06, rnd(), 6'h00, 1'h0, 1'h0, 1'h0);
        op(1, 3, 5'h07, rnd(), 6'h00, 1'h0, 1'h0, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h0);
        for (int i = 6; i < 9; i++) begin
            acc(1'h0, 1'h0, i[4:0], 32'h0);
        end
        $display("test results done");
        ctl(1'h1, 5'h1F, 32'h01000000, 1'h0);
        op(0, 3, 5'h04, 32'h80001234, 6'h00, 1'h1, 1'h0, 1'h0);
        ctl(1'h1, 5'h1F, 32'h00000000, 1'h0);
        op(0, 4, 5'h05, rnd(), 6'h00, 1'h1, 1'h0, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h1);
        ctl(1'h1, 5'h1F, 32'h00000000, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h0);
        for (int i = 3; i < 6; i++) begin
            acc(1'h0, 1'h0, i[4:0], 32'h0);
        end
        $display("test flush and retry done");
        // Enabled cause traps the result: no store, flags kept, cause set
        ctl(1'h1, 5'h1F, 32'h00000080, 1'h0);
        op(0, 3, 5'h0A, rnd(), 6'h01, 1'h0, 1'h0, 1'h0);
        ctl(1'h0, 5'h1F, 32'h0, 1'h1);
        ctl(1'h0, 5'h1F, 32'h0, 1'h0);
        ctl(1'h1, 5'h1F, 32'h00001080, 1'h0);
        ctl(1'h1, 5'h1F, 32'h00000000, 1'h0);
        acc(1'h0, 1'h0, 5'h0A, 32'h0);
        // Clock enable low: a write offered meanwhile must not land
        @(negedge clk) ce = 1'h0;
        {acc_valid, acc_write, acc_operand, acc_idx, acc_wdata} =
            {1'h1, 1'h1, 1'h0, 5'h09, rnd()};
        repeat (2) @(negedge clk);
        chk_bit("frozen", acc_done, 1'h0);
        {acc_valid, ce} = 2'h1;
        acc(1'h0, 1'h0, 5'h09, 32'h0);
        chk_data("exceptions", got_exc, exp_exc);
        $display("test enables and freeze done");
        print_verdict();
    end
endmodule // tb_fp_coproc_state
